/* core/ctp_pkg.sv */
// ctp_pkg: register map, field positions and constants of the compact 10-bit timer.
// assumes a byte-wide register port; clocked at 125 MHz by the enclosing system.
package ctp_pkg;
    // register indices
    localparam logic [2:0] ADDR_CTRL0  = 3'h0;  // enable and period bits
    localparam logic [2:0] ADDR_CTRL1  = 3'h1;  // timer_control_1
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;  // count_value_low
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;  // count_value_high
    localparam logic [2:0] ADDR_MA_LO  = 3'h4;  // match_a_low
    localparam logic [2:0] ADDR_MA_HI  = 3'h5;  // match_a_high
    localparam logic [2:0] ADDR_FLAGS  = 3'h6;  // match flags, write 1 to clear
    // control 0 fields
    localparam int CTRL0_ENABLE = 3;
    localparam int CTRL0_PER_LSB = 0;
    // control 1 fields
    localparam int CTRL1_MODE_LSB = 6;
    localparam int CTRL1_ACT_LSB  = 4;
    localparam int CTRL1_INIT     = 3;
    localparam int CTRL1_INVERT   = 2;
    localparam int CTRL1_SWAP     = 1;
    localparam int CTRL1_CLRSEL   = 0;
    // flag register fields
    localparam int FLAG_A = 0;
    localparam int FLAG_P = 1;
    // widths and reset values
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_MAX   = 10'h3FF;
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // modes
    localparam logic [1:0] MODE_CMP   = 2'h0;
    localparam logic [1:0] MODE_PWM   = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    // output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW  = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TGL  = 2'h3;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ctp_req_t;
endpackage : ctp_pkg

/* core/ctp_timer.sv */
// ctp_timer: compact 10-bit count-up timer with compare, timer and PWM modes.
// assumes one clock; software on a byte port, read data one cycle after the read strobe.
// Notes on behaviour
// - compare mode: A match drives pin high, low, toggles, or nothing for 00
// - requested level equal to initial level gives no visible pin change
// - enable rising edge returns the pin to its initial level
// - init bit: initial level in compare, active level in PWM, unused in timer
// - invert bit inverts the pin, ignored in timer mode
// - swap 0: P sets period, A duty; swap 1: reversed
// - clear select 1: A match clears; 0: P match, overflow when period zero
// - in PWM the clear select is ignored; swap bit picks the clearing comparator
// - live count readable as low and high byte, upper bits zero, not writable
// - match A readable and writable as two bytes, resets to zero
// - mode 00 compare, 10 PWM, 11 timer
// - clear select 0 in compare or timer raises both A and P flags
// - clear select 1 in compare or timer raises only the A flag, never the P flag
// - clear select 1 with A value zero rolls over at 3FF, no A flag
// - in compare mode only A match changes the pin
// - timer mode behaves like compare mode but never drives the pin
// - PWM raises both flags; period register clears, other sets duty
// - swap 0: period is P times 128, zero means 1024; duty is A
// - duty equal to or above period keeps output active all period
// - swap 1: period is A; duty is P times 128, zero means 1024
// - PWM counting continues while action forces the pin with 00 or 01
// - action decode per mode; PWM 00 inactive, 01 active, 10 wave
// - enable rising clears counter, falling stops it holding the count
// - comparator P compares period bits with counter bits 9..7
`timescale 1ns/1ps
`default_nettype none

module ctp_timer (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // register port
    input  wire ctp_pkg::ctp_req_t   req,
    output logic              [7:0]  rdata,
    // pin and request
    output logic                     timer_out_pin,
    output logic                     timer_out_oe,
    output logic                     timer_irq
);

    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [9:0]  match_a_value_q;
    logic [9:0]  cnt_q;
    logic [9:0]  cnt_d;
    logic        en_prev_q;
    logic        match_a_flag_q;
    logic        match_p_flag_q;
    logic        cmp_lvl_q;
    logic        pwm_act_q;
    logic [7:0]  rdata_q;
    logic        pin_q;
    logic        oe_q;
    logic        irq_q;

    // field decode
    wire         timer_enable     = ctrl0_q[ctp_pkg::CTRL0_ENABLE];
    wire  [2:0]  period_top_bits  = ctrl0_q[ctp_pkg::CTRL0_PER_LSB +: 3];
    wire  [1:0]  op_mode          = ctrl1_q[ctp_pkg::CTRL1_MODE_LSB +: 2];
    wire  [1:0]  out_action       = ctrl1_q[ctp_pkg::CTRL1_ACT_LSB +: 2];
    wire         out_init_level   = ctrl1_q[ctp_pkg::CTRL1_INIT];
    wire         out_invert       = ctrl1_q[ctp_pkg::CTRL1_INVERT];
    wire         period_duty_swap = ctrl1_q[ctp_pkg::CTRL1_SWAP];
    wire         clear_select     = ctrl1_q[ctp_pkg::CTRL1_CLRSEL];
    wire         is_pwm   = (op_mode == ctp_pkg::MODE_PWM);
    wire         is_cmp   = (op_mode == ctp_pkg::MODE_CMP);
    wire         is_timer = (op_mode == ctp_pkg::MODE_TIMER);
    wire         en_rise  = timer_enable & ~en_prev_q;

    // register access decode
    function automatic logic hit(input logic [2:0] a, input logic [2:0] ref_addr);
        hit = (a == ref_addr);
    endfunction
    wire         wr_c0  = req.wr & hit(req.addr, ctp_pkg::ADDR_CTRL0);
    wire         wr_c1  = req.wr & hit(req.addr, ctp_pkg::ADDR_CTRL1);
    wire         wr_alo = req.wr & hit(req.addr, ctp_pkg::ADDR_MA_LO);
    wire         wr_ahi = req.wr & hit(req.addr, ctp_pkg::ADDR_MA_HI);
    wire         wr_flg = req.wr & hit(req.addr, ctp_pkg::ADDR_FLAGS);

    // comparators, sampled on the count before it advances
    // top-bit period compare
    wire         p_hit  = timer_enable & (period_top_bits != 3'h0) &
                          (cnt_q[9:7] == period_top_bits - 3'h1) & (cnt_q[6:0] == 7'h7F);
    wire         ovf    = timer_enable & (cnt_q == ctp_pkg::CNT_MAX);
    wire         a_hit  = timer_enable & (match_a_value_q != 10'h000) &
                          (cnt_q == match_a_value_q - 10'h001);
    // clear source: swap in PWM, clear select otherwise
    wire         use_a_clr = is_pwm ? period_duty_swap : clear_select;
    wire         p_clr  = p_hit | (ovf & (period_top_bits == 3'h0));
    wire         clr    = use_a_clr ? (a_hit | ovf) : p_clr;
    // both flags unless A clears outside PWM
    // no P flag with clear select set outside PWM
    wire         set_p  = (is_pwm | ~clear_select) & (p_hit | (ovf & (period_top_bits == 3'h0)));
    wire         set_a  = a_hit;

    // counter clear on rise, hold when off
    // counter runs regardless of action field
    always_comb begin
        cnt_d = cnt_q;
        if (en_rise) begin
            cnt_d = 10'h000;
        end else if (timer_enable) begin
            cnt_d = clr ? 10'h000 : cnt_q + 10'h001;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q     <= 10'h000;
            en_prev_q <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            en_prev_q <= timer_enable;
        end
    end

    // control and match registers
    // match A bytes reset to zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl0_q         <= ctp_pkg::RESET_REG;
            ctrl1_q         <= ctp_pkg::RESET_REG;
            match_a_value_q <= 10'h000;
        end else begin
            if (wr_c0) ctrl0_q <= req.wdata;
            if (wr_c1) ctrl1_q <= req.wdata;
            if (wr_alo) match_a_value_q[7:0] <= req.wdata;
            if (wr_ahi) match_a_value_q[9:8] <= req.wdata[1:0];
        end
    end

    // sticky flags, set wins over write-one clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            match_a_flag_q <= 1'b0;
            match_p_flag_q <= 1'b0;
        end else begin
            match_a_flag_q <= set_a | (match_a_flag_q & ~(wr_flg & req.wdata[ctp_pkg::FLAG_A]));
            match_p_flag_q <= set_p | (match_p_flag_q & ~(wr_flg & req.wdata[ctp_pkg::FLAG_P]));
        end
    end

    // compare-mode level; a request equal to the held level shows nothing
    // action on A match
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmp_lvl_q <= 1'b0;
        end else if (en_rise) begin
            cmp_lvl_q <= out_init_level;
        end else if (a_hit) begin
            unique case (out_action)
                ctp_pkg::ACT_NONE: cmp_lvl_q <= cmp_lvl_q;
                ctp_pkg::ACT_LOW:  cmp_lvl_q <= 1'b0;
                ctp_pkg::ACT_HIGH: cmp_lvl_q <= 1'b1;
                ctp_pkg::ACT_TGL:  cmp_lvl_q <= ~cmp_lvl_q;
            endcase
        end
    end

    // PWM duty: swap 0 duty is A, swap 1 duty is P times 128 (zero as 1024)
    // swap 0: P period, A duty; swap 1: A period, P duty
    wire  [10:0] duty_p = (period_top_bits == 3'h0) ? 11'h400 : {1'b0, period_top_bits, 7'h00};
    wire  [10:0] duty   = period_duty_swap ? duty_p : {1'b0, match_a_value_q};
    // active from clear to duty match
    // duty at or beyond period never reached, stays active
    wire  [10:0] next_pos = {1'b0, cnt_d};
    wire         pwm_act_d = timer_enable ? (next_pos < duty) : pwm_act_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwm_act_q <= 1'b0;
        end else begin
            pwm_act_q <= pwm_act_d;
        end
    end

    // pin composition; timer mode releases the pin
    // action decode per mode
    // init bit as active level in PWM
    logic pwm_lvl;
    always_comb begin
        unique case (out_action)
            ctp_pkg::ACT_NONE: pwm_lvl = ~out_init_level;
            ctp_pkg::ACT_LOW:  pwm_lvl = out_init_level;
            ctp_pkg::ACT_HIGH: pwm_lvl = pwm_act_q ? out_init_level : ~out_init_level;
            ctp_pkg::ACT_TGL:  pwm_lvl = ~out_init_level;  // undefined code: held inactive
        endcase
    end
    wire         pin_d = (is_pwm ? pwm_lvl : cmp_lvl_q) ^ out_invert;
    wire         oe_d  = ~is_timer & (is_pwm | is_cmp);

    // read mux; unmapped addresses read zero
    logic [7:0] rmux;
    always_comb begin
        rmux = ctp_pkg::READ_ZERO;
        unique case (req.addr)
            ctp_pkg::ADDR_CTRL0:  rmux = ctrl0_q;
            ctp_pkg::ADDR_CTRL1:  rmux = ctrl1_q;
            ctp_pkg::ADDR_CNT_LO: rmux = cnt_q[7:0];
            ctp_pkg::ADDR_CNT_HI: rmux = {6'h00, cnt_q[9:8]};
            ctp_pkg::ADDR_MA_LO:  rmux = match_a_value_q[7:0];
            ctp_pkg::ADDR_MA_HI:  rmux = {6'h00, match_a_value_q[9:8]};
            ctp_pkg::ADDR_FLAGS:  rmux = {6'h00, match_p_flag_q, match_a_flag_q};
            default:              rmux = ctp_pkg::READ_ZERO;
        endcase
    end

    // registered outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
            pin_q   <= 1'b0;
            oe_q    <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= req.rd ? rmux : 8'h00;
            pin_q   <= pin_d;
            oe_q    <= oe_d;
            irq_q   <= match_a_flag_q | match_p_flag_q;
        end
    end

    assign rdata         = rdata_q;
    assign timer_out_pin = pin_q;
    assign timer_out_oe  = oe_q;
    assign timer_irq     = irq_q;

    // assertions
    a_enable_clears_cnt: assert property (@(posedge clock) disable iff (!nrst)
        en_rise |=> cnt_q == 10'h000) else $error("count not cleared on enable rise");
    a_stop_holds_cnt: assert property (@(posedge clock) disable iff (!nrst)
        (!timer_enable && !$rose(timer_enable)) |=> $stable(cnt_q)) else $error("count moved while off");
    a_no_p_flag_clrsel: assert property (@(posedge clock) disable iff (!nrst)
        (clear_select && !is_pwm && !match_p_flag_q) |=> !match_p_flag_q || $past(wr_c1))
        else $error("P flag raised with A clearing");
    a_flag_sticky: assert property (@(posedge clock) disable iff (!nrst)
        (match_a_flag_q && !wr_flg) |=> match_a_flag_q) else $error("A flag lost");
    a_init_restore: assert property (@(posedge clock) disable iff (!nrst)
        (en_rise && !wr_c1) |=> cmp_lvl_q == $past(out_init_level)) else $error("initial level not restored");
    a_timer_no_drive: assert property (@(posedge clock) disable iff (!nrst)
        is_timer |=> !timer_out_oe) else $error("pin driven in timer mode");
    a_cnt_read_high: assert property (@(posedge clock) disable iff (!nrst)
        (req.rd && req.addr == ctp_pkg::ADDR_CNT_HI) |=> rdata[7:2] == 6'h00)
        else $error("count high byte upper bits set");
    a_a_clear_cnt: assert property (@(posedge clock) disable iff (!nrst)
        (a_hit && use_a_clr && !en_rise) |=> cnt_q == 10'h000) else $error("A match did not clear");
    a_p_clear_cnt: assert property (@(posedge clock) disable iff (!nrst)
        (p_hit && !use_a_clr && !en_rise) |=> cnt_q == 10'h000) else $error("P match did not clear");
    a_a_flag_set: assert property (@(posedge clock) disable iff (!nrst)
        a_hit |=> match_a_flag_q) else $error("A flag not raised");

    // further guards on comparators, pin and PWM shape
    // sequences for the two edges of one PWM period
    sequence s_pwm_clear;
        is_pwm && clr && !en_rise && (duty != 11'h000);
    endsequence
    sequence s_pwm_duty_end;
        is_pwm && timer_enable && !en_rise && !clr && (next_pos == duty);
    endsequence

    a_pwm_start_act: assert property (@(posedge clock) disable iff (!nrst)
        s_pwm_clear |=> pwm_act_q)
        else $error("PWM not active after clear");

    a_pwm_end_act: assert property (@(posedge clock) disable iff (!nrst)
        s_pwm_duty_end |=> !pwm_act_q)
        else $error("PWM still active after duty");

    a_p_match_pos: assert property (@(posedge clock) disable iff (!nrst)
        p_hit |-> cnt_q[6:0] == 7'h7F)
        else $error("P match off boundary");

    a_zero_a_silent: assert property (@(posedge clock) disable iff (!nrst)
        (match_a_value_q == 10'h000) |-> !set_a)
        else $error("A flag with zero value");

    a_wrap_at_max: assert property (@(posedge clock) disable iff (!nrst)
        (ovf && use_a_clr && !en_rise) |=> cnt_q == 10'h000)
        else $error("count did not wrap at maximum");

    a_p_keeps_level: assert property (@(posedge clock) disable iff (!nrst)
        (is_cmp && p_hit && !a_hit && !en_rise) |=> $stable(cmp_lvl_q))
        else $error("P match moved the level");

    a_timer_flags: assert property (@(posedge clock) disable iff (!nrst)
        (is_timer && a_hit) |=> match_a_flag_q)
        else $error("timer mode lost A flag");

    a_pwm_forced_on: assert property (@(posedge clock) disable iff (!nrst)
        (is_pwm && out_action == ctp_pkg::ACT_LOW) |=> timer_out_pin == $past(out_init_level ^ out_invert))
        else $error("forced active level wrong");

    a_pwm_undef_off: assert property (@(posedge clock) disable iff (!nrst)
        (is_pwm && out_action == ctp_pkg::ACT_TGL) |=> timer_out_pin == $past(~out_init_level ^ out_invert))
        else $error("undefined action not inactive");

    a_pwm_counts: assert property (@(posedge clock) disable iff (!nrst)
        (is_pwm && timer_enable && !en_rise && !clr) |=> cnt_q == $past(cnt_q) + 10'h001)
        else $error("PWM count stalled");

    a_full_duty: assert property (@(posedge clock) disable iff (!nrst)
        (is_pwm && timer_enable && !period_duty_swap && duty >= duty_p) |=> pwm_act_q)
        else $error("full duty dropped");

    a_pwm_no_a_clr: assert property (@(posedge clock) disable iff (!nrst)
        (is_pwm && !period_duty_swap && clear_select && a_hit && !p_clr && !en_rise)
        |=> cnt_q != 10'h000)
        else $error("A match cleared in PWM");

    // P does not clear when swapped
    a_swap_no_p_clr: assert property (@(posedge clock) disable iff (!nrst)
        (is_pwm && period_duty_swap && p_hit && !a_hit && !ovf && !en_rise)
        |=> cnt_q != 10'h000)
        else $error("P match cleared when swapped");

    a_flag_clear: assert property (@(posedge clock) disable iff (!nrst)
        (wr_flg && req.wdata[ctp_pkg::FLAG_A] && !set_a) |=> !match_a_flag_q)
        else $error("A flag not cleared");

    a_irq_follows: assert property (@(posedge clock) disable iff (!nrst)
        (match_a_flag_q || match_p_flag_q) |=> timer_irq)
        else $error("request not raised");

    a_oe_modes: assert property (@(posedge clock) disable iff (!nrst)
        (is_cmp || is_pwm) |=> timer_out_oe)
        else $error("pin not driven");

    a_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
        !req.rd |=> rdata == 8'h00)
        else $error("read data outside read");

    a_p_flag_set: assert property (@(posedge clock) disable iff (!nrst)
        set_p |=> match_p_flag_q)
        else $error("P flag not raised");

endmodule : ctp_timer

`default_nettype wire

/* verification/ctp_load_model.sv */
// ctp_load_model: external load on the timer pin, measures the pulse shape it sees.
// assumes the line is pulled low whenever the timer does not drive it.
`timescale 1ns/1ps
`default_nettype none

module ctp_load_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // pin as driven by the timer
    input  wire logic        pin,
    input  wire logic        oe,
    // measured shape
    output logic      [15:0] per_len,
    output logic      [15:0] hi_len,
    output logic      [15:0] rises
);
    logic        line;
    logic        last_q;
    logic [15:0] run_q;
    logic [15:0] hrun_q;
    // pull-down wins while undriven, so a stale level never leaks through
    assign line = oe & pin;
    // rise to rise period and high time within it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {last_q, run_q, hrun_q, per_len, hi_len, rises} <= '0;
        end else begin
            last_q <= line;
            if (line && !last_q) begin
                per_len <= run_q;
                hi_len  <= hrun_q;
                rises   <= rises + 16'h0001;
                run_q   <= 16'h0001;
                hrun_q  <= 16'h0001;
            end else begin
                run_q  <= run_q + 16'h0001;
                hrun_q <= hrun_q + 16'(line);
            end
        end
    end
endmodule // ctp_load_model

`default_nettype wire

/* verification/tb_top.sv */
// tb_top: self-checking bench for the compact timer, reads checked through a queue.
// assumes ctp_pkg and ctp_timer compiled first; load model sits on the pin.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic              clock = 1'b0;
    logic              nrst = 1'b0;
    ctp_pkg::ctp_req_t req = '0;
    logic [7:0]        rdata;
    logic              pin;
    logic              oe;
    logic              irq;
    logic [15:0]       per_len;
    logic [15:0]       hi_len;
    logic [15:0]       rises;
    logic [15:0]       r0;
    logic              rd_seen = 1'b0;
    logic [7:0]        exp_q[$];
    logic [9:0]        ma;
    int                miscompares = 0;
    int                cmp_count = 0;

    always #4 clock = ~clock;

    ctp_timer dut_u (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata),
                     .timer_out_pin(pin), .timer_out_oe(oe), .timer_irq(irq));
    ctp_load_model load_u (.clock(clock), .nrst(nrst), .pin(pin), .oe(oe),
                           .per_len(per_len), .hi_len(hi_len), .rises(rises));

    task automatic conclude;
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g,
                       input logic [15:0] tol);
        cmp_count++;
        if ($isunknown(g) || g + tol < e || g > e + tol) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_seen)
            chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata}, 16'h0000);
        rd_seen <= req.rd;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
    endtask

    // reconfigure from stopped, then let it run n cycles
    task automatic run(input logic [7:0] c1, input logic [7:0] c0, input logic [9:0] a,
                       input int n);
        wr(ctp_pkg::ADDR_CTRL0, 8'h00);
        wr(ctp_pkg::ADDR_FLAGS, 8'h03);
        wr(ctp_pkg::ADDR_MA_LO, a[7:0]);
        wr(ctp_pkg::ADDR_MA_HI, {6'h00, a[9:8]});
        wr(ctp_pkg::ADDR_CTRL1, c1);
        wr(ctp_pkg::ADDR_CTRL0, c0);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // watchdog well beyond the expected run of about 5400 cycles
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        conclude();
    end

    initial begin
        void'($urandom(42017));
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        ma = 10'($urandom_range(1023, 0));
        wr(ctp_pkg::ADDR_MA_LO, ma[7:0]);
        wr(ctp_pkg::ADDR_MA_HI, {6'h3F, ma[9:8]});
        rd(ctp_pkg::ADDR_MA_LO, ma[7:0]);
        rd(ctp_pkg::ADDR_MA_HI, {6'h00, ma[9:8]});
        wr(ctp_pkg::ADDR_CNT_LO, 8'hFF);
        rd(ctp_pkg::ADDR_CNT_LO, 8'h00);
        run(8'h21, 8'h08, 10'd40, 100);
        chk("pin", 16'h1, 16'(pin), 16'h0);
        chk("irq", 16'h1, 16'(irq), 16'h0);
        rd(ctp_pkg::ADDR_FLAGS, 8'h01);
        rd(ctp_pkg::ADDR_CNT_HI, 8'h00);
        run(8'h11, 8'h08, 10'd40, 10);
        chk("pin", 16'h0, 16'(pin), 16'h0);
        repeat (60) @(posedge clock);
        chk("pin", 16'h0, 16'(pin), 16'h0);
        run(8'h31, 8'h08, 10'd40, 300);
        chk("toggle period", 16'd80, per_len, 16'h1);
        chk("toggle high", 16'd40, hi_len, 16'h1);
        run(8'h01, 8'h08, 10'd0, 1100);
        rd(ctp_pkg::ADDR_FLAGS, 8'h00);
        run(8'h20, 8'h09, 10'd40, 300);
        rd(ctp_pkg::ADDR_FLAGS, 8'h03);
        run(8'hE0, 8'h09, 10'd40, 300);
        chk("oe", 16'h0, 16'(oe), 16'h0);
        rd(ctp_pkg::ADDR_FLAGS, 8'h03);
        run(8'h60, 8'h09, 10'd40, 20);
        chk("oe", 16'h0, 16'(oe), 16'h0);
        run(8'hA8, 8'h09, 10'd32, 400);
        chk("pwm period", 16'd128, per_len, 16'h1);
        chk("pwm high", 16'd32, hi_len, 16'h1);
        rd(ctp_pkg::ADDR_FLAGS, 8'h03);
        run(8'hAC, 8'h09, 10'd32, 400);
        chk("inverted high", 16'd96, hi_len, 16'h1);
        run(8'hAA, 8'h09, 10'd300, 1000);
        chk("swap period", 16'd300, per_len, 16'h1);
        chk("swap high", 16'd128, hi_len, 16'h1);
        run(8'hA8, 8'h09, 10'd200, 300);
        r0 = rises;
        repeat (300) @(posedge clock);
        chk("full duty rises", r0, rises, 16'h0);
        chk("pin", 16'h1, 16'(pin), 16'h0);
        run(8'h98, 8'h09, 10'd32, 300);
        chk("pin", 16'h1, 16'(pin), 16'h0);
        rd(ctp_pkg::ADDR_FLAGS, 8'h03);
        run(8'h88, 8'h09, 10'd32, 300);
        chk("pin", 16'h0, 16'(pin), 16'h0);
        wr(ctp_pkg::ADDR_CTRL0, 8'h00);
        wr(ctp_pkg::ADDR_FLAGS, 8'h03);
        rd(ctp_pkg::ADDR_FLAGS, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk("irq", 16'h0, 16'(irq), 16'h0);
        conclude();
    end
endmodule // tb_top

`default_nettype wire
